// [design/fifo_cascade_pkg.sv]
// package: register map, field positions, reset values and timing counts of the cascadable fifo
package fifo_cascade_pkg;

    // =====================================================================
    // sizes
    localparam int DEPTH_WORDS_DEF  = 8192;   // 18-bit depth, doubled in 9-bit width
    localparam int DATA_W           = 18;
    localparam int NARROW_W         = 9;
    localparam int ADDR_W           = 8;
    localparam int OFS_W            = 16;

    // =====================================================================
    // register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] OFFSET_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] INT_STAT_OFS = 8'h0C;
    localparam logic [7:0] INT_MASK_OFS = 8'h10;

    // =====================================================================
    // control fields
    localparam int CTRL_WIDTH_BIT  = 0;       // width_select: 1 = 9-bit
    localparam int CTRL_FALL_BIT   = 1;       // fall_through_mode
    localparam int CTRL_MRST_BIT   = 2;       // master reset pulse
    localparam int CTRL_PRST_BIT   = 3;       // partial reset pulse
    localparam int CTRL_REPLAY_BIT = 4;       // replay_request pulse

    // offset register fields
    localparam int OFS_AE_LSB = 0;
    localparam int OFS_AF_LSB = 16;
    localparam logic [15:0] AE_OFS_RST = 16'h007F;
    localparam logic [15:0] AF_OFS_RST = 16'h007F;

    // status register fields
    localparam int STAT_FLAG_LSB = 16;        // seven flag bits from here

    // interrupt bits
    localparam int INT_FULL  = 0;
    localparam int INT_EMPTY = 1;
    localparam int INT_AFULL = 2;
    localparam int INT_OVFL  = 3;
    localparam int INT_W     = 4;

    // =====================================================================
    // timing bounds in clock cycles (one clock, so fast clock = read clock)
    localparam int FWL_FAST_CYCLES = 10;
    localparam int FWL_READ_CYCLES = 3;
    localparam int FWL_MAX_CYCLES  = FWL_FAST_CYCLES + FWL_READ_CYCLES;
    localparam int BUBBLE_CYCLES   = 3;

    // flag update state after replay
    typedef enum logic [1:0] {
        st_run    = 2'b01,
        st_replay = 2'b10
    } flag_state_type;

endpackage

// [design/fifo_store.sv]
// storage array of the fifo with a registered read port
module fifo_store #(
    parameter int WIDTH = 18,
    parameter int AW    = 14
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic             re,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    // one write and one registered read per cycle
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end

endmodule // fifo_store

// [design/fifo_cascade_expansion.sv]
// cascadable fifo with selectable width, fall-through mode, replay and apb control
// Contract
// R1 - after replay, level flags resume updating at the read of location zero
// R2 - writer puts at most D-2 words between reset and replay
// R3 - depth is D words at 18 bits and 2D words at 9 bits
// R4 - flag edges may differ one cycle between side-by-side devices
// R5 - width expansion ANDs empty/full flags, ORs ready lines in fall-through
// R6 - in 9-bit width data bits 9 to 17 are unused and read zero
// R7 - output control lines of several devices are never wired together
// R8 - depth chain links data outputs to next inputs, depths add up
// R9 - every device in a depth chain is reset into fall-through mode
// R10 - word reaching the outputs drives output ready low, feeding the next device
// R11 - output ready latency at most ten fast plus three read cycles
// R12 - chain transit is sum of device latencies plus one read cycle each
// R13 - only the first word into an empty chain sees ripple delay
// R14 - a new free location drives input ready low, space bubbles upward
// R15 - input ready asserts within three write cycles per device after a read
// R16 - frequency select per device, transfer clock on the faster clock; here one clock (pclk) and no frequency select
// R17 - in fall-through the first word moves to the output unrequested
// R18 - after replay read once output ready low, write after that or 14 cycles
// R19 - all expanded devices share width select and flag mode
module fifo_cascade_expansion
    import fifo_cascade_pkg::*;
#(
    parameter int DEPTH_WORDS = fifo_cascade_pkg::DEPTH_WORDS_DEF
) (
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [fifo_cascade_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                        pwdata,
    output logic      [31:0]                        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic                               wr_en,
    input  wire logic [fifo_cascade_pkg::DATA_W-1:0] wr_data,
    input  wire logic                               rd_en,
    output logic      [fifo_cascade_pkg::DATA_W-1:0] rd_data,
    output logic                                    empty_indicator_n,
    output logic                                    full_indicator_n,
    output logic                                    output_ready_n,
    output logic                                    input_ready_n,
    output logic                                    half_level_flag_n,
    output logic                                    almost_empty_flag_n,
    output logic                                    almost_full_flag_n,
    output logic                                    irq
);
    import fifo_cascade_pkg::*;

    localparam int AW = $clog2(2 * DEPTH_WORDS);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] CAP_WIDE   = CW'(DEPTH_WORDS);
    localparam logic [CW-1:0] CAP_NARROW = CW'(2 * DEPTH_WORDS);
    localparam logic [DATA_W-1:0] NARROW_MASK = DATA_W'((1 << NARROW_W) - 1);

    // =====================================================================
    // declarations
    logic              pready_q, pslverr_q, irq_q;
    logic [31:0]       prdata_q, prdata_d;
    logic              hit_d;
    logic              wr_acc;
    logic              width_q, fall_q, width_cfg_q, fall_cfg_q;
    logic [OFS_W-1:0]  ae_ofs_q, af_ofs_q;
    logic [INT_W-1:0]  int_stat_q, int_mask_q, int_ev;
    logic              mrst, prst, replay, clear_data;
    logic [CW-1:0]     cap_q, mem_count_q;
    logic [AW-1:0]     wr_ptr_q, rd_ptr_q;
    logic              wr_ok, fetch, fetch_q, take, out_valid_q;
    logic [DATA_W-1:0] mem_rdata, wr_masked, rd_data_q;
    flag_state_type    fstate_q;
    logic              is_full, is_empty, is_half, is_ae, is_af;
    logic              empty_n_q, full_n_q, oready_n_q, iready_n_q;
    logic              half_n_q, ae_n_q, af_n_q;

    // =====================================================================
    // apb slave
    assign wr_acc = psel && penable && pwrite && pready_q;

    // read mux and address decode
    always_comb begin
        prdata_d = 32'h0000_0000;
        hit_d    = 1'b1;
        case (paddr)
            CTRL_OFS: begin
                prdata_d[CTRL_WIDTH_BIT] = width_cfg_q;
                prdata_d[CTRL_FALL_BIT]  = fall_cfg_q;
            end
            OFFSET_OFS: begin
                prdata_d = {af_ofs_q, ae_ofs_q};
            end
            STATUS_OFS: begin
                prdata_d[CW-1:0] = mem_count_q;
                prdata_d[STAT_FLAG_LSB +: 7] = {af_n_q, ae_n_q, half_n_q, iready_n_q,
                                                oready_n_q, full_n_q, empty_n_q};
            end
            INT_STAT_OFS: begin
                prdata_d[INT_W-1:0] = int_stat_q;
            end
            INT_MASK_OFS: begin
                prdata_d[INT_W-1:0] = int_mask_q;
            end
            default: begin
                hit_d = 1'b0;
            end
        endcase
    end

    // zero-wait answer prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready_q  <= 1'b1;
            pslverr_q <= !hit_d;
            prdata_q  <= pwrite ? 32'h0000_0000 : prdata_d;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // control pulses
    assign mrst       = wr_acc && paddr == CTRL_OFS && pwdata[CTRL_MRST_BIT];
    assign prst       = wr_acc && paddr == CTRL_OFS && pwdata[CTRL_PRST_BIT];
    assign replay     = wr_acc && paddr == CTRL_OFS && pwdata[CTRL_REPLAY_BIT] && !mrst && !prst;
    assign clear_data = mrst || prst;

    // configuration: staged by software, taken at master reset only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_cfg_q <= 1'b0;
            fall_cfg_q  <= 1'b0;
            width_q     <= 1'b0;
            fall_q      <= 1'b0;
            cap_q       <= CAP_WIDE;
        end else if (wr_acc && paddr == CTRL_OFS) begin
            width_cfg_q <= pwdata[CTRL_WIDTH_BIT];
            fall_cfg_q  <= pwdata[CTRL_FALL_BIT];
            if (mrst) begin
                width_q <= pwdata[CTRL_WIDTH_BIT];
                fall_q  <= pwdata[CTRL_FALL_BIT];
                cap_q   <= pwdata[CTRL_WIDTH_BIT] ? CAP_NARROW : CAP_WIDE; // R3
            end
        end
    end

    // flag offsets survive partial reset, return to default on master reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ae_ofs_q <= AE_OFS_RST;
            af_ofs_q <= AF_OFS_RST;
        end else if (mrst) begin
            ae_ofs_q <= AE_OFS_RST;
            af_ofs_q <= AF_OFS_RST;
        end else if (wr_acc && paddr == OFFSET_OFS) begin
            ae_ofs_q <= pwdata[OFS_AE_LSB +: OFS_W];
            af_ofs_q <= pwdata[OFS_AF_LSB +: OFS_W];
        end
    end

    // =====================================================================
    // data path
    assign wr_ok     = wr_en && mem_count_q != cap_q && !clear_data;
    assign wr_masked = width_q ? (wr_data & NARROW_MASK) : wr_data; // R6
    assign take      = fall_q && rd_en && out_valid_q && !oready_n_q; // only a word the pins show

    // fall-through fetches unrequested into an empty output stage
    always_comb begin
        if (clear_data || replay || mem_count_q == '0) begin
            fetch = 1'b0;
        end else if (fall_q) begin
            fetch = (!out_valid_q || take) && !fetch_q; // R17 R10 R13
        end else begin
            fetch = rd_en;
        end
    end

    fifo_store #(
        .WIDTH (DATA_W),
        .AW    (AW)
    ) store (
        .clk   (pclk),
        .we    (wr_ok),
        .waddr (wr_ptr_q),
        .wdata (wr_masked),
        .re    (fetch),
        .raddr (rd_ptr_q),
        .rdata (mem_rdata)
    );

    // write pointer wraps at the selected depth
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
        end else if (clear_data) begin
            wr_ptr_q <= '0;
        end else if (wr_ok) begin
            wr_ptr_q <= ({1'b0, wr_ptr_q} == cap_q - 1'b1) ? '0 : wr_ptr_q + 1'b1; // R3
        end
    end

    // read pointer, replay rewinds to location zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_q <= '0;
        end else if (clear_data || replay) begin
            rd_ptr_q <= '0;
        end else if (fetch) begin
            rd_ptr_q <= ({1'b0, rd_ptr_q} == cap_q - 1'b1) ? '0 : rd_ptr_q + 1'b1;
        end
    end

    // words held in memory, the output stage not counted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_count_q <= '0;
        end else if (clear_data) begin
            mem_count_q <= '0;
        end else if (replay) begin
            mem_count_q <= {1'b0, wr_ptr_q}; // valid while writer kept to at most D-2 words
        end else begin
            mem_count_q <= mem_count_q + CW'(wr_ok) - CW'(fetch); // R14
        end
    end

    // output stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_q     <= 1'b0;
            out_valid_q <= 1'b0;
            rd_data_q   <= '0;
        end else if (clear_data || replay) begin
            fetch_q     <= 1'b0;
            out_valid_q <= 1'b0;
        end else begin
            fetch_q <= fetch;
            if (fetch_q) begin
                out_valid_q <= 1'b1; // R17 R10
                rd_data_q   <= width_q ? (mem_rdata & NARROW_MASK) : mem_rdata; // R6
            end else if (take) begin
                out_valid_q <= 1'b0;
            end
        end
    end

    // =====================================================================
    // flags
    assign is_full  = mem_count_q == cap_q;
    assign is_empty = mem_count_q == '0;
    assign is_half  = mem_count_q > (cap_q >> 1);
    assign is_ae    = {1'b0, mem_count_q} <= ae_ofs_q;
    assign is_af    = {2'b00, mem_count_q} + {1'b0, af_ofs_q} >= {2'b00, cap_q};

    // level flags frozen from replay until location zero is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fstate_q <= st_run;
        end else begin
            case (fstate_q)
                st_run: begin
                    if (replay) begin
                        fstate_q <= st_replay;
                    end
                end
                st_replay: begin
                    if (clear_data || (fetch && rd_ptr_q == '0)) begin
                        fstate_q <= st_run; // R1
                    end
                end
                default: begin
                    fstate_q <= st_run;
                end
            endcase
        end
    end

    // handshake flags, registered so each edge lands on one clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty_n_q  <= 1'b0;
            full_n_q   <= 1'b1;
            oready_n_q <= 1'b1;
            iready_n_q <= 1'b0;
        end else begin
            empty_n_q  <= !is_empty; // R4
            full_n_q   <= !is_full; // R4
            oready_n_q <= !(fall_q && out_valid_q && !take && !clear_data && !replay); // R10 R11 R12
            iready_n_q <= is_full; // R14 R15
        end
    end

    // level flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_n_q <= 1'b1;
            ae_n_q   <= 1'b0;
            af_n_q   <= 1'b1;
        end else if (clear_data) begin
            half_n_q <= 1'b1;
            ae_n_q   <= 1'b0;
            af_n_q   <= 1'b1;
        end else if (fstate_q == st_run) begin
            half_n_q <= !is_half; // R1
            ae_n_q   <= !is_ae;
            af_n_q   <= !is_af;
        end
    end

    // =====================================================================
    // interrupts
    always_comb begin
        int_ev            = '0;
        int_ev[INT_FULL]  = is_full && full_n_q;
        int_ev[INT_EMPTY] = is_empty && empty_n_q;
        int_ev[INT_AFULL] = is_af && af_n_q && fstate_q == st_run;
        int_ev[INT_OVFL]  = wr_en && !wr_ok;
    end

    // sticky status, write one clears, a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= '0;
        end else if (wr_acc && paddr == INT_STAT_OFS) begin
            int_stat_q <= (int_stat_q & ~pwdata[INT_W-1:0]) | int_ev;
        end else begin
            int_stat_q <= int_stat_q | int_ev;
        end
    end

    // mask and level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            if (wr_acc && paddr == INT_MASK_OFS) begin
                int_mask_q <= pwdata[INT_W-1:0];
            end
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    // =====================================================================
    // outputs
    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign rd_data             = rd_data_q;
    assign empty_indicator_n   = empty_n_q;
    assign full_indicator_n    = full_n_q;
    assign output_ready_n      = oready_n_q;
    assign input_ready_n       = iready_n_q;
    assign half_level_flag_n   = half_n_q;
    assign almost_empty_flag_n = ae_n_q;
    assign almost_full_flag_n  = af_n_q;
    assign irq                 = irq_q;

endmodule // fifo_cascade_expansion

// [verif/fifo_cascade_expansion_checker.sv]
// checker: port-level assertions of the cascadable fifo
module fifo_cascade_expansion_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [17:0] rd_data,
    input wire logic        empty_indicator_n,
    input wire logic        full_indicator_n,
    input wire logic        output_ready_n,
    input wire logic        input_ready_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import fifo_cascade_pkg::*;
    logic ft_q;
    logic narrow_q;
    // ========
    // mode and width follow a master-reset write to control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ft_q     <= 1'b0;
            narrow_q <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == CTRL_OFS && pwdata[CTRL_MRST_BIT]) begin
            ft_q     <= pwdata[CTRL_FALL_BIT];
            narrow_q <= pwdata[CTRL_WIDTH_BIT];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ========
    // bus handshake
    a_setup_gets_ready: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_error_needs_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // ========
    // fifo flags and narrow data
    a_ready_full_pair: assert property (input_ready_n == !full_indicator_n)
        else $error("input ready disagrees with full");
    a_space_bubbles_up: assert property (
        input_ready_n && rd_en && !wr_en && (!ft_q || !output_ready_n) ##1 !wr_en |-> ##[0:2] !input_ready_n)
        else $error("input ready late after read");
    a_first_word_falls: assert property (
        ft_q && output_ready_n && wr_en && !input_ready_n |-> ##[1:13] !output_ready_n)
        else $error("first word latency exceeded");
    a_standard_or_high: assert property (!ft_q && !$past(ft_q) |-> output_ready_n)
        else $error("output ready low in standard mode");
    a_narrow_upper_zero: assert property (
        narrow_q && $changed(rd_data) |-> rd_data[17:9] == 9'h000)
        else $error("upper data bits in narrow width");
    a_write_clears_empty: assert property (
        !ft_q && !empty_indicator_n && wr_en |-> ##[1:2] empty_indicator_n)
        else $error("empty not cleared by write");
endmodule // fifo_cascade_expansion_checker

bind fifo_cascade_expansion fifo_cascade_expansion_checker chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .empty_indicator_n(empty_indicator_n),
    .full_indicator_n(full_indicator_n), .output_ready_n(output_ready_n),
    .input_ready_n(input_ready_n)
);

// [verif/fifo_reader_model.sv]
// partner: downstream reader taking words from the fifo outputs
module fifo_reader_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        drain,
    input  wire logic        pulse,
    input  wire logic        output_ready_n,
    input  wire logic [17:0] rd_data,
    output logic             rd_en,
    output logic      [17:0] got_q,
    output logic      [7:0]  cnt_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ready_any_n;
    // composite output ready: OR of every device's line through a gate, never wired together
    assign ready_any_n = |{output_ready_n};
    // ========
    // drain reads only while output ready is low, skip the stale cycle after a take; pulse reads whatever output ready is
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_en <= 1'b0;
        end else begin
            rd_en <= pulse | (drain & ~ready_any_n & ~rd_en);
        end
    end
    // keep the last word taken and count them, as a next device would
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            got_q <= 18'h00000;
            cnt_q <= 8'h00;
        end else if (rd_en && !ready_any_n) begin
            got_q <= rd_data;
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // fifo_reader_model

// [verif/fifo_cascade_expansion_tb_top.sv]
// testbench: register table, then full, fall-through and replay cases
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, ex, sn); end end
module fifo_cascade_expansion_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fifo_cascade_pkg::*;
    typedef struct packed { logic [7:0] a; logic [31:0] d; logic e; } row_type;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        wr_en = 1'b0;
    logic [17:0] wr_data = 18'h0;
    logic        drain = 1'b0;
    logic        pulse = 1'b0;
    logic [31:0] prdata;
    logic [17:0] rd_data, got;
    logic [7:0]  cnt;
    logic        pready, pslverr, rd_en, irq, empty_n, full_n, oready_n, iready_n, half_n, aempty_n, afull_n;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    row_type     rows [5] = '{'{CTRL_OFS, 32'h0, 1'b0}, '{OFFSET_OFS, 32'h007F_007F, 1'b0},
        '{STATUS_OFS, 32'h0016_0000, 1'b0}, '{INT_MASK_OFS, 32'h0, 1'b0}, '{8'h14, 32'h0, 1'b1}};

    always #4 pclk = ~pclk;

    fifo_cascade_expansion #(.DEPTH_WORDS(8)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .empty_indicator_n(empty_n),
        .full_indicator_n(full_n), .output_ready_n(oready_n), .input_ready_n(iready_n),
        .half_level_flag_n(half_n), .almost_empty_flag_n(aempty_n),
        .almost_full_flag_n(afull_n), .irq(irq));
    fifo_reader_model rdr (
        .clk(pclk), .rst_n(presetn), .drain(drain), .pulse(pulse), .output_ready_n(oready_n),
        .rd_data(rd_data), .rd_en(rd_en), .got_q(got), .cnt_q(cnt));

    // ========
    // bus and stream tasks
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        `CHK("pready", 1'b1, pready)
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic burst(input int n, input logic [17:0] b);
        for (int k = 0; k < n; k++) begin
            wr_en   <= 1'b1;
            wr_data <= b + 18'(k);
            @(posedge pclk);
        end
        wr_en <= 1'b0;
    endtask
    task automatic sread(output logic [17:0] d);
        pulse <= 1'b1;
        @(posedge pclk);
        pulse <= 1'b0;
        repeat (4) @(posedge pclk);
        d = rd_data;
    endtask
    task automatic waitn(input logic [7:0] n);
        int k;
        k = 0;
        while (cnt !== n && k < 200) begin
            @(posedge pclk);
            k++;
        end
        `CHK("taken count", n, cnt)
    endtask

    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    // ========
    // main sequence
    initial begin
        logic [31:0] q;
        logic        e;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[k]) begin
            apb(1'b0, rows[k].a, 32'h0, q, e);
            `CHK("reg data", rows[k].d, q)
            `CHK("reg error", rows[k].e, e)
        end
        `CHK("level pins", 3'b001, {afull_n, aempty_n, half_n})
        // standard mode: one word past capacity is dropped
        burst(9, 18'h2A000);
        repeat (2) @(posedge pclk);
        `CHK("full", 1'b0, full_n)
        `CHK("input ready", 1'b1, iready_n)
        apb(1'b0, STATUS_OFS, 32'h0, q, e);
        `CHK("count", 15'h0008, q[14:0])
        apb(1'b0, INT_STAT_OFS, 32'h0, q, e);
        `CHK("drop event", 1'b1, q[INT_OVFL])
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, INT_MASK_OFS, 32'h0000_0008, q, e);
        repeat (2) @(posedge pclk);
        `CHK("irq raised", 1'b1, irq)
        apb(1'b1, INT_STAT_OFS, 32'h0000_0008, q, e);
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        for (int k = 0; k < 8; k++) begin
            sread(q[17:0]);
            `CHK("std word", 18'h2A000 + 18'(k), q[17:0])
        end
        `CHK("empty", 1'b0, empty_n)
        // nine-bit fall-through, reader stalled while filling
        apb(1'b1, CTRL_OFS, 32'h0000_0007, q, e);
        burst(17, 18'h3FE40);
        repeat (16) @(posedge pclk);
        `CHK("word out unread", 1'b0, oready_n)
        `CHK("narrow data", 18'h00040, rd_data)
        apb(1'b0, STATUS_OFS, 32'h0, q, e);
        `CHK("narrow count", 15'h0010, q[14:0])
        `CHK("narrow full", 1'b0, full_n)
        `CHK("half full", 1'b0, half_n)
        drain <= 1'b1;
        waitn(8'h01);
        `CHK("first taken", 18'h00040, got)
        waitn(8'h11);
        `CHK("last taken", 18'h00050, got)
        // partial reset, three words, then replay from the start
        apb(1'b1, CTRL_OFS, 32'h0000_000B, q, e);
        burst(3, 18'h00100);
        waitn(8'h14);
        `CHK("before replay", 18'h00102, got)
        apb(1'b1, CTRL_OFS, 32'h0000_0013, q, e);
        waitn(8'h15);
        `CHK("replay first", 18'h00100, got)
        print_verdict();
    end
endmodule // fifo_cascade_expansion_tb_top
